// >>> testbench/lpm_ctrl_chk.sv
// Checker of mode entry and wake behaviour at the controller ports.
// Assumes one clock domain; bound to every lpm_ctrl instance.
`timescale 1ns/10ps
module lpm_ctrl_chk
  import lpm_pkg::*;
#(
  parameter logic [HOUR_W-1:0] HOUR_CYCLES = HOUR_CYC // Hour in clocks
) (
  input wire logic clk, // System clock
  input wire logic rst, // Reset
  input wire logic cen, // Clock enable
  input wire logic hreadyout, // Slave ready
  input wire logic hresp, // Response
  input wire idle_s idle, // Activity levels
  input wire wake_s wake, // Events
  input wire mode_e mode, // Power mode
  input wire logic ram_keep, // Retention level
  input wire logic ram_clear, // RAM drop pulse
  input wire logic tmr_restore, // Timer restore pulse
  input wire logic cold_boot // Cold boot pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Some peripheral or task still working
  logic busy;
  assign busy = !idle.fw_idle || idle.uart_xfer || idle.spi_xfer ||
    idle.i2c_xfer || idle.adc_on || idle.flash_open;
  // Deep Sleep left for Active
  sequence s_deep_exit;
    mode == M_DEEP ##1 mode == M_ACTIVE;
  endsequence
  a_busy_blocks: assert property (mode == M_ACTIVE && busy |=>
    mode == M_ACTIVE) else $error("entry while busy");
  a_adv_no_deep: assert property (mode == M_ACTIVE && idle.adv_on |=>
    mode != M_DEEP) else $error("deep entry while advertising");
  a_conn_shallow: assert property (mode == M_ACTIVE && idle.conn_up |=>
    !(mode inside {M_DEEP, M_BACKUP})) else $error("deep entry, link up");
  a_sleep_wake: assert property (cen && mode == M_SLEEP &&
    (wake.key_scan_wake || wake.rtc_alarm || wake.tmr_expire ||
    wake.remote_pkt) |=> mode == M_ACTIVE && tmr_restore)
    else $error("sleep wake missed");
  a_backup_wake: assert property (cen && mode == M_BACKUP &&
    (wake.key_scan_wake || wake.rtc_alarm) |=> mode == M_ACTIVE)
    else $error("backup wake missed");
  a_deep_hold: assert property (mode == M_DEEP |=>
    mode inside {M_DEEP, M_ACTIVE}) else $error("deep left wrongly");
  a_deep_cold: assert property (s_deep_exit |-> cold_boot)
    else $error("deep exit without cold boot");
  a_brief_quiet: assert property (mode == M_BRIEF |->
    !(tmr_restore || ram_clear || cold_boot)) else $error("brief wake noisy");
  a_keep_active: assert property (mode == M_ACTIVE |-> !ram_keep)
    else $error("retention held in active");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
endmodule // lpm_ctrl_chk

bind lpm_ctrl lpm_ctrl_chk #(.HOUR_CYCLES(HOUR_CYCLES)) u_chk (
  .clk(clk), .rst(rst), .cen(cen), .hreadyout(hreadyout), .hresp(hresp),
  .idle(idle), .wake(wake), .mode(mode), .ram_keep(ram_keep),
  .ram_clear(ram_clear), .tmr_restore(tmr_restore), .cold_boot(cold_boot)
);

// >>> testbench/tb_top.sv
// Self-checking bench of the low-power mode controller.
// Assumes lpm_pkg, lpm_ctrl, wake_src and the checker compiled first.
`timescale 1ns/10ps
module tb_top;
  import lpm_pkg::*;
  // Ordinary case: control, activity, expected mode
  typedef struct packed {
    logic [10:0] ctrl;
    logic [10:0] idl;
    mode_e m;
  } row_s;
  localparam logic [10:0] OK = 11'h400; // Everything idle
  logic clk, rst, hsel, hwrite, hreadyout, hresp; // Clock, reset, bus
  logic cen; // Clock enable
  logic [31:0] haddr, hwdata, hrdata, rd; // Bus words, last read
  logic [1:0] htrans; // Transfer type
  logic pin_a, pin_b, ram_keep, ram_clear, tmr_restore, cold_boot; // Pins
  idle_s idle; // Activity
  wake_s wake; // Events
  mode_e mode; // Present mode
  int miscompares, checks_done, briefs; // Counters
  row_s rows [16]; // Ordinary cases
  lpm_ctrl #(.HOUR_CYCLES(HOUR_W'(50))) u_dut (.clk(clk), .rst(rst),
    .cen(cen), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .idle(idle),
    .wake(wake), .wake_pin_a(pin_a), .wake_pin_b(pin_b), .mode(mode),
    .ram_keep(ram_keep), .ram_clear(ram_clear),
    .tmr_restore(tmr_restore), .cold_boot(cold_boot));
  wake_src u_src (.clk(clk), .idle(idle), .wake(wake), .pin_a(pin_a),
    .pin_b(pin_b));
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Brief-wake cycles
  always @(posedge clk) if (mode === M_BRIEF) briefs <= briefs + 1;
  // Value compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  // Mode compare after settling
  task automatic chk_mode(input mode_e exp);
    #1;
    chk({29'h0, mode}, {29'h0, exp});
  endtask
  // One AHB-Lite single word transfer; read data lands in rd
  task automatic bus(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // Reset pulse mid-run
  task automatic do_rst();
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
  endtask
  // Verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    #100000;
    miscompares++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    {rst, hsel, hwrite, htrans, haddr, hwdata} = {1'b1, 68'h0};
    cen = 1'b1;
    {miscompares, checks_done, briefs} = '0;
    rows = '{{11'h000, OK, M_ACTIVE}, {11'h007, OK, M_DEEP},
      {11'h007, 11'h410, M_BACKUP}, {11'h007, 11'h408, M_SLEEP},
      {11'h007, 11'h000, M_ACTIVE}, {11'h007, 11'h600, M_ACTIVE},
      {11'h007, 11'h500, M_ACTIVE}, {11'h007, 11'h480, M_ACTIVE},
      {11'h007, 11'h440, M_ACTIVE}, {11'h007, 11'h420, M_ACTIVE},
      {11'h001, OK, M_SLEEP}, {11'h002, OK, M_BACKUP},
      {11'h00F, OK, M_ACTIVE}, {11'h00F, 11'h406, M_SLEEP},
      {11'h00F, 11'h405, M_SLEEP}, {11'h00F, 11'h404, M_DEEP}};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      do_rst();
      u_src.set_lvl(rows[i].idl, 1'b0);
      bus(1'b1, OFS_CTRL, {21'h0, rows[i].ctrl});
      repeat (3) @(posedge clk);
      chk_mode(rows[i].m);
      $display("row %0d done", i);
    end
    // Sleep woken by alarm, cause read twice
    do_rst();
    u_src.set_lvl(OK, 1'b0);
    bus(1'b1, OFS_CTRL, 32'h001);
    repeat (2) @(posedge clk);
    // Clock enable low: the alarm is not seen
    cen <= 1'b0;
    u_src.pulse(6, OK);
    chk_mode(M_SLEEP);
    @(posedge clk);
    cen <= 1'b1;
    u_src.pulse(6, 11'h000);
    chk_mode(M_ACTIVE);
    chk({30'h0, tmr_restore, ram_clear}, 32'h3);
    bus(1'b0, OFS_CAUSE, 32'h0);
    chk(rd, 32'h008);
    bus(1'b0, OFS_CAUSE, 32'h0);
    chk(rd, 32'h008);
    $display("sleep wake done");
    // Backup ignores timer, wakes on advertising count
    do_rst();
    bus(1'b1, OFS_ADV, 32'h2);
    bus(1'b1, OFS_CTRL, 32'h023);
    u_src.set_lvl(OK, 1'b0);
    repeat (2) @(posedge clk);
    u_src.pulse(5, OK);
    u_src.pulse(2, OK);
    chk_mode(M_BACKUP);
    u_src.pulse(2, 11'h000);
    // Count registers first, the wake follows one cycle later
    @(posedge clk);
    chk_mode(M_ACTIVE);
    bus(1'b0, OFS_CAUSE, 32'h0);
    chk(rd, 32'h080);
    $display("backup wake done");
    // Deep Sleep gated and woken by pin A
    do_rst();
    u_src.set_lvl(OK, 1'b1);
    bus(1'b1, OFS_CTRL, 32'h147);
    repeat (6) @(posedge clk);
    chk_mode(M_ACTIVE);
    u_src.set_lvl(OK, 1'b0);
    repeat (6) @(posedge clk);
    chk_mode(M_DEEP);
    u_src.pulse(6, OK);
    chk_mode(M_DEEP);
    u_src.set_lvl(11'h000, 1'b1);
    repeat (4) @(posedge clk);
    chk_mode(M_ACTIVE);
    chk({31'h0, cold_boot}, 32'h1);
    bus(1'b0, OFS_CAUSE, 32'h0);
    chk(rd, 32'h001);
    bus(1'b0, OFS_STAT, 32'h0);
    chk(rd & 32'h8, 32'h8);
    bus(1'b0, 12'h010, 32'h0);
    chk(rd, 32'h0);
    $display("deep wake done");
    // Hourly self-wake, retention, scheduled radio event
    do_rst();
    bus(1'b1, OFS_CTRL, 32'h411);
    briefs = 0;
    u_src.set_lvl(OK, 1'b0);
    repeat (75) @(posedge clk);
    chk(briefs, 32'h1);
    chk({31'h0, ram_keep}, 32'h1);
    u_src.pulse(1, OK);
    chk_mode(M_BRIEF);
    u_src.pulse(0, OK);
    chk_mode(M_SLEEP);
    $display("brief wake done");
    // Pin B at inactive level lets Backup entry through, then wakes it
    do_rst();
    u_src.set_pin_b(1'b1);
    u_src.set_lvl(OK, 1'b0);
    bus(1'b1, OFS_CTRL, 32'h082);
    repeat (6) @(posedge clk);
    chk_mode(M_BACKUP);
    u_src.set_pin_b(1'b0);
    repeat (4) @(posedge clk);
    chk_mode(M_ACTIVE);
    bus(1'b0, OFS_CAUSE, 32'h0);
    chk(rd, 32'h002);
    $display("pin b wake done");
    tally_and_finish();
  end
endmodule // tb_top

// >>> testbench/wake_src.sv
// Far-side model: activity levels, wake events and the wake pins.
// Assumes the bench calls its tasks from the clk domain.
`timescale 1ns/10ps
module wake_src
  import lpm_pkg::*;
(
  input wire logic clk, // System clock
  output idle_s idle, // Activity levels
  output wake_s wake, // Event pulses
  output logic pin_a, // Wake pin A
  output logic pin_b // Wake pin B
);
  // Busy and quiet at time zero
  initial begin
    idle = 11'h000;
    wake = 8'h00;
    pin_a = 1'b0;
    pin_b = 1'b0;
  end
  // New activity level and pin A level at one edge
  task automatic set_lvl(input logic [10:0] v, input logic a);
    @(posedge clk);
    idle <= v;
    pin_a <= a;
  endtask
  // New pin B level at one edge
  task automatic set_pin_b(input logic b);
    @(posedge clk);
    pin_b <= b;
  endtask
  // One-cycle event; activity changes at the same edge
  task automatic pulse(input int b, input logic [10:0] v);
    @(posedge clk);
    wake <= wake_s'(8'h01 << b);
    idle <= v;
    @(posedge clk);
    wake <= 8'h00;
  endtask
endmodule // wake_src

// >>> verilog/lpm_ctrl.sv
// Low-power mode entry and wake controller with AHB-Lite registers.
// Assumes activity and event inputs come from logic on clk; the two
// wake pins arrive asynchronously and are synchronised here.
//
// Summary of operation
// - Modes enabled individually; none enabled, no entry
// - Enter lowest-power enabled mode whose conditions hold
// - Busy firmware tasks block entry
// - Wake pin must sit at inactive level
// - UART, SPI or I2C transfer blocks entry
// - Opened but idle UART does not block
// - Running ADC blocks entry
// - Open flash access blocks entry
// - Deep Sleep needs no advertising
// - Backup and Deep Sleep need no connection
// - User mode needs task waiting on event
// - User mode deeper modes need timers stopped
// - Sleep wake sources listed return to Active
// - Hourly silent self-wake when long count runs
// - Hourly interval is fixed
// - Backup wake sources listed return to Active
// - Auto-advertise count reached wakes from Backup
// - Deep exit by pin or reset, cold boot
// - Scheduled radio events wake briefly, silently
// - Wake cause recorded and readable
// - RAM lost unless retention configured
// - Timers restored and counters reset after Sleep
`timescale 1ns/10ps

module lpm_ctrl
  import lpm_pkg::*;
#(
  parameter logic [HOUR_W-1:0] HOUR_CYCLES = HOUR_CYC // Hour in clocks
) (
  input wire logic clk, // System clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic cen, // Clock enable, freezes all state
  input wire logic hsel, // AHB slave select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size, word only
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB bus ready
  output logic hreadyout, // AHB slave ready
  output logic hresp, // AHB response, always OKAY
  output logic [31:0] hrdata, // AHB read data
  input wire idle_s idle, // Activity indications
  input wire wake_s wake, // Wake and radio events
  input wire logic wake_pin_a, // Wake pin A, asynchronous
  input wire logic wake_pin_b, // Wake pin B, asynchronous
  output mode_e mode, // Present power mode
  output logic ram_keep, // RAM retention held in low power
  output logic ram_clear, // Pulse: RAM contents to be dropped
  output logic tmr_restore, // Pulse: restore timers, reset counts
  output logic cold_boot // Pulse: Deep Sleep exit via cold boot
);

  // Whole state of the controller
  typedef struct packed {
    mode_e mode; // Present mode
    mode_e ret; // Mode to resume after a brief wake
    logic [SYNC_N-1:0] pa; // Pin A synchroniser
    logic [SYNC_N-1:0] pb; // Pin B synchroniser
    logic [CTRL_W-1:0] ctrl; // Control register
    logic [ADV_W-1:0] adv_cfg; // Advertising count target
    logic [ADV_W-1:0] adv_cnt; // Advertising packets sent
    logic [CAUSE_W-1:0] cause; // Recorded wake cause
    logic deep_wk; // Last wake came from Deep Sleep
    logic [HOUR_W-1:0] hour; // Hour counter in Sleep
    logic ram_keep; // Retention in force
    logic ram_clr; // RAM drop pulse
    logic tmr_rst; // Timer restore pulse
    logic cboot; // Cold boot pulse
    logic dsel; // Data phase pending
    logic dwr; // Data phase is a write
    logic [11:0] dadr; // Data phase offset
    logic rdy; // Ready output
    logic [31:0] rdata; // Read data output
  } st_s;

  st_s s_r; // Registered state
  st_s s_nxt; // Next state

  // True when the address falls on a mapped word
  function automatic logic mapped(input logic [31:0] a);
    mapped = (a[31:4] == 28'h0000000) && (a[1:0] == 2'h0);
  endfunction

  // Settled pin level equals the level given in pol
  function automatic logic pin_act(input logic [SYNC_N-1:0] p,
                                   input logic pol);
    pin_act = (p[1] == p[2]) && (p[2] == pol);
  endfunction

  // Condition terms
  logic common_ok; // Entry allowed for any mode
  logic pins_ok; // Wake pins at inactive level
  logic bk_ok; // Backup conditions
  logic dp_ok; // Deep Sleep conditions
  logic any_en; // Some mode enabled
  logic pa_w; // Pin A wake
  logic pb_w; // Pin B wake
  logic adv_hit; // Advertising target reached
  logic [CAUSE_W-1:0] wk; // Wake sources seen this cycle
  logic [31:0] stat; // Status word

  // Entry conditions and wake source decoding
  always_comb begin
    any_en = s_r.ctrl[C_SLEEP] | s_r.ctrl[C_BACKUP] |
             s_r.ctrl[C_DEEP];
    pa_w = s_r.ctrl[C_PA_EN] & pin_act(s_r.pa, s_r.ctrl[C_PA_POL]);
    pb_w = s_r.ctrl[C_PB_EN] & pin_act(s_r.pb, s_r.ctrl[C_PB_POL]);
    // Pin must be settled at the opposite of its wake level
    pins_ok = (!s_r.ctrl[C_PA_EN] ||
               pin_act(s_r.pa, !s_r.ctrl[C_PA_POL])) &&
              (!s_r.ctrl[C_PB_EN] ||
               pin_act(s_r.pb, !s_r.ctrl[C_PB_POL]));
    // UART open state is not an input: only transfers count
    common_ok = any_en && pins_ok && idle.fw_idle &&
                !(idle.uart_xfer || idle.spi_xfer ||
                  idle.i2c_xfer) &&
                !idle.adc_on &&
                !idle.flash_open &&
                (!s_r.ctrl[C_USER] || idle.user_wait);
    bk_ok = !idle.conn_up &&
            (!s_r.ctrl[C_USER] ||
             !(idle.sec_tmr_on || idle.ms_tmr_on));
    dp_ok = bk_ok && !idle.adv_on;
    adv_hit = s_r.ctrl[C_AUTOADV] && (s_r.adv_cfg != '0) &&
              (s_r.adv_cnt >= s_r.adv_cfg);
    wk = '0;
    wk[W_PA] = pa_w;
    wk[W_PB] = pb_w;
    wk[W_KEY] = wake.key_scan_wake;
    wk[W_RTC] = wake.rtc_alarm;
    wk[W_TMR] = wake.tmr_expire;
    wk[W_PKT] = wake.remote_pkt;
    wk[W_CONN] = wake.conn_req;
    wk[W_ADV] = adv_hit;
    stat = '0;
    stat[2:0] = s_r.mode;
    stat[3] = s_r.deep_wk;
    stat[4] = common_ok;
    stat[5] = bk_ok;
    stat[6] = dp_ok;
    stat[7] = pins_ok;
  end

  // Next-state logic
  always_comb begin
    s_nxt = s_r;
    s_nxt.ram_clr = 1'b0;
    s_nxt.tmr_rst = 1'b0;
    s_nxt.cboot = 1'b0;
    s_nxt.rdy = 1'b1;
    // Only the second and third stages are ever compared
    s_nxt.pa = {s_r.pa[SYNC_N-2:0], wake_pin_a};
    s_nxt.pb = {s_r.pb[SYNC_N-2:0], wake_pin_b};

    // AHB data phase: apply a pending write
    if (s_r.dsel && s_r.dwr) begin
      case (s_r.dadr)
        OFS_CTRL: s_nxt.ctrl = hwdata[CTRL_W-1:0];
        OFS_ADV: s_nxt.adv_cfg = hwdata[ADV_W-1:0];
        default: s_nxt.dwr = 1'b0; // Read-only or unmapped: ignored
      endcase
    end
    // AHB address phase: capture and prepare read data
    s_nxt.dsel = hsel && htrans[1] && hready;
    if (hsel && htrans[1] && hready) begin
      s_nxt.dwr = hwrite;
      s_nxt.dadr = haddr[11:0];
      s_nxt.rdata = '0;
      if (!hwrite && mapped(haddr)) begin
        case (haddr[11:0])
          OFS_CTRL: s_nxt.rdata[CTRL_W-1:0] = s_r.ctrl;
          OFS_STAT: s_nxt.rdata = stat;
          OFS_ADV: s_nxt.rdata[ADV_W-1:0] = s_r.adv_cfg;
          OFS_CAUSE: s_nxt.rdata[CAUSE_W-1:0] = s_r.cause;
          default: s_nxt.rdata = '0;
        endcase
      end
    end

    // Power mode sequencing
    case (s_r.mode)
      M_ACTIVE: begin
        if (common_ok) begin
          // Deepest enabled mode that qualifies wins
          if (s_r.ctrl[C_DEEP] && dp_ok) begin
            s_nxt.mode = M_DEEP;
          end else if (s_r.ctrl[C_BACKUP] && bk_ok) begin
            s_nxt.mode = M_BACKUP;
          end else if (s_r.ctrl[C_SLEEP]) begin
            s_nxt.mode = M_SLEEP;
          end
          if (s_nxt.mode != M_ACTIVE) begin
            s_nxt.cause = '0;
            s_nxt.deep_wk = 1'b0;
            s_nxt.hour = '0;
            s_nxt.adv_cnt = '0;
            s_nxt.ram_keep = s_r.ctrl[C_RAMRET];
          end
        end
      end
      M_SLEEP: begin
        s_nxt.hour = s_r.hour + 1'b1;
        if ((wk & ~(CAUSE_W'(1) << W_CONN) &
             ~(CAUSE_W'(1) << W_ADV)) != '0) begin
          s_nxt.mode = M_ACTIVE;
          s_nxt.cause = wk & ~(CAUSE_W'(1) << W_CONN) &
                        ~(CAUSE_W'(1) << W_ADV);
          s_nxt.tmr_rst = 1'b1;
          s_nxt.ram_clr = !s_r.ram_keep;
          s_nxt.ram_keep = 1'b0;
        end else if (wake.radio_evt) begin
          s_nxt.ret = M_SLEEP;
          s_nxt.mode = M_BRIEF;
        end else if (s_r.ctrl[C_LONGCNT] &&
                     s_r.hour >= HOUR_CYCLES - 1'b1) begin
          // Fixed interval, no cause recorded
          s_nxt.ret = M_SLEEP;
          s_nxt.mode = M_BRIEF;
          s_nxt.hour = '0;
        end
      end
      M_BACKUP: begin
        if (wake.adv_sent && s_r.ctrl[C_AUTOADV]) begin
          s_nxt.adv_cnt = s_r.adv_cnt + 1'b1;
        end
        if ((wk[W_PA] | wk[W_PB] | wk[W_KEY] | wk[W_RTC] | wk[W_ADV]) ||
            (wk[W_CONN] && s_r.ctrl[C_AUTOADV])) begin
          s_nxt.mode = M_ACTIVE;
          s_nxt.cause = wk & ~(CAUSE_W'(1) << W_TMR) &
                        ~(CAUSE_W'(1) << W_PKT);
          if (!s_r.ctrl[C_AUTOADV]) begin
            s_nxt.cause[W_CONN] = 1'b0;
          end
          s_nxt.ram_clr = !s_r.ram_keep;
          s_nxt.ram_keep = 1'b0;
        end else if (wake.radio_evt) begin
          s_nxt.ret = M_BACKUP;
          s_nxt.mode = M_BRIEF;
        end
      end
      M_DEEP: begin
        // Only the wake pins leave Deep Sleep; reset acts directly
        if (pa_w || pb_w) begin
          s_nxt.mode = M_ACTIVE;
          s_nxt.cause[W_PA] = pa_w;
          s_nxt.cause[W_PB] = pb_w;
          s_nxt.deep_wk = 1'b1;
          s_nxt.cboot = 1'b1;
          s_nxt.ram_clr = !s_r.ram_keep;
          s_nxt.ram_keep = 1'b0;
        end
      end
      M_BRIEF: begin
        // Silent radio service, then back to the saved mode
        if (wake.radio_done || s_r.ret == M_SLEEP &&
            !wake.radio_evt && s_r.hour == '0) begin
          s_nxt.mode = s_r.ret;
        end
      end
      default: s_nxt.mode = M_ACTIVE;
    endcase
  end

  // State register, frozen while cen is low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '{mode: M_ACTIVE, ret: M_SLEEP, pa: '0, pb: '0,
               ctrl: CTRL_RST, adv_cfg: '0, adv_cnt: '0,
               cause: CAUSE_RST, deep_wk: 1'b0, hour: '0,
               ram_keep: 1'b0, ram_clr: 1'b0, tmr_rst: 1'b0,
               cboot: 1'b0, dsel: 1'b0, dwr: 1'b0, dadr: '0,
               rdy: 1'b1, rdata: '0};
    end else if (cen) begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register
  assign hreadyout = s_r.rdy;
  assign hresp = 1'b0 & s_r.rdy;
  assign hrdata = s_r.rdata;
  assign mode = s_r.mode;
  assign ram_keep = s_r.ram_keep;
  assign ram_clear = s_r.ram_clr;
  assign tmr_restore = s_r.tmr_rst;
  assign cold_boot = s_r.cboot;

endmodule // lpm_ctrl

// >>> verilog/lpm_pkg.sv
// Constants, types and register map of the low-power mode controller.
// Assumes a 200 MHz system clock and an AHB-Lite register port.
package lpm_pkg;
  // Clock and hourly self-wake timing
  localparam longint CLK_HZ = 64'd200_000_000; // System clock rate
  localparam longint HOUR_S = 64'd3600; // Self-wake interval, seconds
  localparam int HOUR_W = 40; // Width of the hour counter
  localparam logic [HOUR_W-1:0] HOUR_CYC = HOUR_W'(HOUR_S * CLK_HZ);
  // Register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000; // Mode enables, config
  localparam logic [11:0] OFS_STAT = 12'h004; // Mode and blockers
  localparam logic [11:0] OFS_ADV = 12'h008; // Auto-advertise count
  localparam logic [11:0] OFS_CAUSE = 12'h00C; // Wake cause
  // Control register bit positions
  localparam int C_SLEEP = 0; // Sleep enable
  localparam int C_BACKUP = 1; // Backup enable
  localparam int C_DEEP = 2; // Deep Sleep enable
  localparam int C_USER = 3; // User-application operation
  localparam int C_RAMRET = 4; // RAM retention requested
  localparam int C_AUTOADV = 5; // Auto-advertise in Backup
  localparam int C_PA_EN = 6; // Pin A is a wake input
  localparam int C_PB_EN = 7; // Pin B is a wake input
  localparam int C_PA_POL = 8; // Pin A wake level
  localparam int C_PB_POL = 9; // Pin B wake level
  localparam int C_LONGCNT = 10; // Long second count running
  localparam int CTRL_W = 11; // Control width
  localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000; // Control reset
  // Wake cause bit positions
  localparam int W_PA = 0; // Pin A
  localparam int W_PB = 1; // Pin B
  localparam int W_KEY = 2; // Key scan
  localparam int W_RTC = 3; // RTC alarm
  localparam int W_TMR = 4; // Second or millisecond timer
  localparam int W_PKT = 5; // Remote packet
  localparam int W_CONN = 6; // Connection request
  localparam int W_ADV = 7; // Advertising count reached
  localparam int W_RST = 8; // Reset release
  localparam int CAUSE_W = 9; // Cause width
  localparam logic [CAUSE_W-1:0] CAUSE_RST = 9'h100; // Reset cause
  localparam int ADV_W = 28; // Advertising count width
  localparam int SYNC_N = 3; // Pin synchroniser depth
  // Power modes, Gray along active-sleep-backup-deep-brief
  typedef enum logic [2:0] {
    M_ACTIVE = 3'h0,
    M_SLEEP = 3'h1,
    M_BACKUP = 3'h3,
    M_DEEP = 3'h2,
    M_BRIEF = 3'h6
  } mode_e;
  // Activity indications that can block entry
  typedef struct packed {
    logic fw_idle; // Firmware tasks idle
    logic uart_xfer; // UART moving data
    logic spi_xfer; // SPI moving data
    logic i2c_xfer; // I2C moving data
    logic adc_on; // ADC operating
    logic flash_open; // Flash access still open
    logic adv_on; // Advertising in progress
    logic conn_up; // Radio connection established
    logic user_wait; // User task waits on event flag
    logic sec_tmr_on; // One-second timer running
    logic ms_tmr_on; // One-millisecond timer running
  } idle_s;
  // On-chip wake and radio event sources, one-cycle pulses
  typedef struct packed {
    logic key_scan_wake; // Key scan wake interrupt
    logic rtc_alarm; // RTC alarm
    logic tmr_expire; // Second or ms timer expiry
    logic remote_pkt; // Packet received from remote
    logic conn_req; // Connection request from remote
    logic adv_sent; // One advertising packet sent
    logic radio_evt; // Scheduled radio event due
    logic radio_done; // Scheduled radio event finished
  } wake_s;
endpackage
